// file: logic/mspwm_cfg.svh
// Register offsets, channel count, reset values and prescaler field width
// What this block does
// - Per-channel clock-select bit picks first or second prescaled clock of its pair.
// - Role bit 0 means master mode; its polarity bit reads back as zero.
// - Role bit 1 means slave mode; pin shows duty pulse after each trigger.
// - Polarity bit 0 gives active-high output, 1 gives active-low output.
// - Enable bit 1 lets counting drive the output; 0 leaves output alone.
// - Output-level bit sets the channel output directly to 0 or 1.
// - One write of go triggers sets running flags; trigger bits self-clear.
// - Master start raises its period event at once, which also triggers slaves that are running or started with it.
// - Master loads reload value, counts down, at zero raises event and reloads.
// - On every master event each running slave above it, up to the next master or stopped slave, loads its own reload value.
// - Slave active one count after event, inactive at zero, then stops.
// - Counters always readable; output level and enable writable while running.
// - Stop clears running flags; counts and slave outputs hold their levels.
// - Halt trigger bits read back as zero, acting only as triggers.
// - Gate bit 0 holds block idle, ignoring writes other than to the gate bit; 1 enables writes.
// - Clearing gate bit initializes all channel registers, output levels to zero.
// - Period is master value plus one counts; duty is slave value counts.
// - Slave value above master plus one gives continuous full-on output.
`ifndef MSPWM_CFG_SVH
`define MSPWM_CFG_SVH
`define MSPWM_NCH 12
`define MSPWM_ADR_GATE 8'h00
`define MSPWM_ADR_PRESC 8'h04
`define MSPWM_ADR_GO 8'h08
`define MSPWM_ADR_HALT 8'h0C
`define MSPWM_ADR_RUN 8'h10
`define MSPWM_ADR_LEVEL 8'h14
`define MSPWM_ADR_DRIVE 8'h18
`define MSPWM_ADR_POL 8'h1C
`define MSPWM_ADR_ROLE 8'h20
`define MSPWM_ADR_CKSEL 8'h24
`define MSPWM_ADR_PIN 8'h28
`define MSPWM_ADR_RELOAD 8'h40
`define MSPWM_ADR_COUNT 8'h80
`define MSPWM_RST_WORD 16'h0000
`define MSPWM_RST_PRESC 16'h0000
`define MSPWM_PRESC_W 4
`endif

// file: logic/mspwm_pkg.sv
// Types shared by the multi-slave PWM timer
package mspwm_pkg;
  typedef logic [11:0] mspwm_chmask_t;
  typedef logic [15:0] mspwm_word_t;
endpackage

// file: logic/mspwm_top.sv
// Multi-slave PWM timer with a classic Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
`include "mspwm_cfg.svh"
module mspwm_top
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Channel pins
  output logic [11:0] pwm_o,
  output logic [11:0] pwm_oe_o
);

  ////////////////////////////////////////////////////////////////////////
  // Software-visible registers
  logic gate;
  logic [15:0] presc;
  mspwm_pkg::mspwm_chmask_t running;
  mspwm_pkg::mspwm_chmask_t level;
  mspwm_pkg::mspwm_chmask_t drive;
  mspwm_pkg::mspwm_chmask_t pol;
  mspwm_pkg::mspwm_chmask_t role;
  mspwm_pkg::mspwm_chmask_t cksel;
  mspwm_pkg::mspwm_word_t reload [0:11];

  // Channel state
  mspwm_pkg::mspwm_word_t count [0:11];
  mspwm_pkg::mspwm_chmask_t armed;

  // Prescaler
  logic [7:0] div_cnt [0:3];
  logic [3:0] tick;
  mspwm_pkg::mspwm_chmask_t ch_tick;

  // Per-cycle strobes
  mspwm_pkg::mspwm_chmask_t go;
  mspwm_pkg::mspwm_chmask_t halt;
  mspwm_pkg::mspwm_chmask_t mevent;
  mspwm_pkg::mspwm_chmask_t trig;
  mspwm_pkg::mspwm_chmask_t set_out;
  mspwm_pkg::mspwm_chmask_t clr_out;

  // Bus
  logic bus_req;
  logic wr;
  logic rd;
  logic [3:0] idx;
  logic [31:0] next_rdata;

  function automatic logic [3:0] chan_idx(input logic [7:0] adr);
    chan_idx = adr[5:2];
  endfunction

  function automatic logic [15:0] wmask(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    wmask = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [11:0] wmask12(input logic [11:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    wmask12 = {sel[1] ? d[11:8] : old[11:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic in_bank(input logic [7:0] adr, input logic [1:0] bank);
    in_bank = adr[7:6] == bank && chan_idx(adr) < 4'd12;
  endfunction

  function automatic logic tick_due(input logic [7:0] cnt, input logic [2:0] expo);
    tick_due = (cnt & ((8'h01 << expo) - 8'h01)) == 8'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus decode; a write lands at the edge that samples ack high
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign wr = bus_req && wb_we_i && wb_ack_o;
  assign rd = bus_req && !wb_we_i && !wb_ack_o;
  assign idx = chan_idx(wb_adr_i);
  assign go = (wr && gate && wb_adr_i == `MSPWM_ADR_GO) ? wb_dat_i[11:0] : 12'h000;
  assign halt = (wr && gate && wb_adr_i == `MSPWM_ADR_HALT) ? wb_dat_i[11:0] : 12'h000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= bus_req && !wb_ack_o;
  end

  // Gate bit; the only register writable while gated
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      gate <= 1'b0;
    else if (wr && wb_adr_i == `MSPWM_ADR_GATE && wb_sel_i[0])
      gate <= wb_dat_i[0];
  end

  // Config registers; gate low wipes them
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !gate)
      presc <= `MSPWM_RST_PRESC;
    else if (wr && wb_adr_i == `MSPWM_ADR_PRESC)
      presc <= wmask(presc, wb_dat_i, wb_sel_i);
  end

  // Level register; a software write wins over the slave edges
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !gate)
      level <= 12'h000;
    else if (wr && wb_adr_i == `MSPWM_ADR_LEVEL)
      level <= wmask12(level, wb_dat_i, wb_sel_i);
    else
      level <= (level | set_out) & ~clr_out;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !gate)
      drive <= 12'h000;
    else if (wr && wb_adr_i == `MSPWM_ADR_DRIVE)
      drive <= wmask12(drive, wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !gate)
      pol <= 12'h000;
    else if (wr && wb_adr_i == `MSPWM_ADR_POL)
      pol <= wmask12(pol, wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !gate)
      role <= 12'h000;
    else if (wr && wb_adr_i == `MSPWM_ADR_ROLE)
      role <= wmask12(role, wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !gate)
      cksel <= 12'h000;
    else if (wr && wb_adr_i == `MSPWM_ADR_CKSEL)
      cksel <= wmask12(cksel, wb_dat_i, wb_sel_i);
  end

  // Reload words, one per channel
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !gate)
    begin
      for (int i = 0; i < 12; i++)
        reload[i] <= `MSPWM_RST_WORD;
    end
    else if (wr && in_bank(wb_adr_i, 2'b01))
      reload[idx] <= wmask(reload[idx], wb_dat_i, wb_sel_i);
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescalers: 3-bit exponent in each 4-bit field per clock, a and b for 0-7, c and d for 8-11
  always_ff @(posedge clk_i)
  begin
    for (int k = 0; k < 4; k++)
    begin
      if (rst_i || !gate)
        div_cnt[k] <= 8'h00;
      else
        div_cnt[k] <= div_cnt[k] + 8'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    for (int k = 0; k < 4; k++)
    begin
      if (rst_i || !gate)
        tick[k] <= 1'b0;
      else
        tick[k] <= tick_due(div_cnt[k], presc[k*4 +: 3]);
    end
  end

  always_comb
  begin
    for (int i = 0; i < 12; i++)
      ch_tick[i] = (i < 8) ? tick[{1'b0, cksel[i]}] : tick[{1'b1, cksel[i]}];
  end

  ////////////////////////////////////////////////////////////////////////
  // Start and stop
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !gate)
      running <= 12'h000;
    else
      running <= (running | go) & ~halt;
  end

  // Master event: on start, or on count tick at zero
  always_comb
  begin
    for (int i = 0; i < 12; i++)
      mevent[i] = !role[i] && (go[i] || (running[i] && ch_tick[i] && count[i] == 16'h0000));
  end

  // Slave trigger from nearest lower master; a slave started with it counts
  always_comb
  begin
    trig = 12'h000;
    for (int i = 1; i < 12; i++)
      if (role[i])
        trig[i] = (role[i-1] ? trig[i-1] : mevent[i-1]) && (running[i] || go[i]);
  end

  ////////////////////////////////////////////////////////////////////////
  // Counters: masters in interval mode, slaves in one-shot mode
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < 12; i++)
    begin
      if (rst_i || !gate)
        count[i] <= `MSPWM_RST_WORD;
      else if (!role[i])
      begin
        if (mevent[i])
          count[i] <= reload[i];
        else if (running[i] && ch_tick[i])
          count[i] <= count[i] - 16'h0001;
      end
      else if (trig[i])
        count[i] <= reload[i];
      else if (running[i] && armed[i] && ch_tick[i] && count[i] != 16'h0000)
        count[i] <= count[i] - 16'h0001;
    end
  end

  // Slave window: armed from trigger until the tick at zero
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < 12; i++)
    begin
      if (rst_i || !gate || !role[i])
        armed[i] <= 1'b0;
      else if (trig[i])
        armed[i] <= 1'b1;
      else if (running[i] && ch_tick[i] && count[i] == 16'h0000)
        armed[i] <= 1'b0;
    end
  end

  // Slave output edges; reload above period never reaches zero, stays active
  always_comb
  begin
    for (int i = 0; i < 12; i++)
    begin
      set_out[i] = 1'b0;
      clr_out[i] = 1'b0;
      if (role[i] && running[i] && drive[i] && armed[i] && ch_tick[i])
      begin
        if (count[i] == 16'h0000)
        begin
          set_out[i] = pol[i];
          clr_out[i] = !pol[i];
        end
        else if (count[i] == reload[i])
        begin
          set_out[i] = !pol[i];
          clr_out[i] = pol[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pwm_o <= 12'h000;
    else
      pwm_o <= level;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pwm_oe_o <= 12'h000;
    else
      pwm_oe_o <= gate ? 12'hFFF : 12'h000;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      `MSPWM_ADR_GATE: next_rdata = {31'h0, gate};
      `MSPWM_ADR_PRESC: next_rdata = {16'h0, presc};
      `MSPWM_ADR_RUN: next_rdata = {20'h0, running};
      `MSPWM_ADR_LEVEL: next_rdata = {20'h0, level};
      `MSPWM_ADR_DRIVE: next_rdata = {20'h0, drive};
      `MSPWM_ADR_POL: next_rdata = {20'h0, pol & role};
      `MSPWM_ADR_ROLE: next_rdata = {20'h0, role};
      `MSPWM_ADR_CKSEL: next_rdata = {20'h0, cksel};
      `MSPWM_ADR_PIN: next_rdata = {20'h0, pwm_o};
      default:
      begin
        if (in_bank(wb_adr_i, 2'b01))
        begin
          next_rdata = {16'h0, reload[idx]};
        end
        else if (in_bank(wb_adr_i, 2'b10))
        begin
          next_rdata = {16'h0, count[idx]};
        end
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (rd)
      wb_dat_o <= next_rdata;
  end

endmodule
`default_nettype wire

// file: bench/mspwm_chk.sv
// Port-level assertions for the multi-slave PWM timer
`timescale 1ns/1ps
`default_nettype none
`include "mspwm_cfg.svh"
module mspwm_chk
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone side
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Channel pins
  input wire logic [11:0] pwm_o,
  input wire logic [11:0] pwm_oe_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_write_keeps: assert property (wb_ack_o && wb_we_i |-> $stable(wb_dat_o))
    else $error("read data moved on write");
  a_oe_uniform: assert property (pwm_oe_o == 12'h000 || pwm_oe_o == 12'hFFF)
    else $error("pin enables not uniform");
  a_reset_quiet: assert property ($fell(rst_i) |-> pwm_o == 12'h000 && pwm_oe_o == 12'h000)
    else $error("pins active after reset");
  a_gate_on: assert property (wb_ack_o && wb_we_i && wb_adr_i == `MSPWM_ADR_GATE
    && wb_sel_i[0] && wb_dat_i[0] |-> ##[0:2] (pwm_oe_o == 12'hFFF))
    else $error("gate on did not enable pins");
  a_gate_clear: assert property ((pwm_oe_o == 12'h000) [*3] |-> pwm_o == 12'h000)
    else $error("pin levels kept while gated");
endmodule
`default_nettype wire

// file: bench/mspwm_load.sv
// Load model on the PWM pins: counts driven-high cycles per pin
`timescale 1ns/1ps
`default_nettype none
module mspwm_load
(
  // Clock and control
  input wire logic clk_i,
  input wire logic clr_i,
  // Pins from the timer
  input wire logic [11:0] pwm_i,
  input wire logic [11:0] pwm_oe_i,
  // High-time per pin
  output logic [15:0] high_cnt [12]
);
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < 12; i++)
    begin
      if (clr_i)
        high_cnt[i] <= 16'h0000;
      else if (pwm_oe_i[i] && pwm_i[i])
        high_cnt[i] <= high_cnt[i] + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// file: bench/mspwm_top_bench.sv
// Self-checking bench for the multi-slave PWM timer
`timescale 1ns/1ps
`default_nettype none
`include "mspwm_cfg.svh"
module mspwm_top_bench;
  typedef struct {logic [7:0] adr; logic [31:0] wr; logic [31:0] exp;} mspwm_row_t;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, clr;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, cnt0;
  logic [11:0] pwm_o, pwm_oe_o, held;
  logic [15:0] high_cnt [12];
  int fail_count = 0;
  int checks = 0;
  mspwm_row_t rows [8] = '{
    '{`MSPWM_ADR_CKSEL, 32'h0F00, 32'h0F00}, '{`MSPWM_ADR_DRIVE, 32'h0F0F, 32'h0F0F},
    '{`MSPWM_ADR_ROLE, 32'h0006, 32'h0006}, '{`MSPWM_ADR_POL, 32'h0FFF, 32'h0006},
    '{8'h44, 32'h1BEEF, 32'hBEEF}, '{`MSPWM_ADR_HALT, 32'h0, 32'h0},
    '{8'h3C, 32'hFFFF, 32'h0}, '{`MSPWM_ADR_LEVEL, 32'hFFFFFA5A, 32'h0A5A}};
  mspwm_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o));
  mspwm_load u_load (.clk_i(clk_i), .clr_i(clr), .pwm_i(pwm_o), .pwm_oe_i(pwm_oe_o),
    .high_cnt(high_cnt));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n++ < 40);
    if (n >= 40)
      fail_count++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic results;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial
  begin
    #400000;
    fail_count++;
    results();
  end
  initial
  begin
    {rst_i, clr, wb_cyc_i, wb_stb_i, wb_we_i} = 5'b11000;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h3;
    wb_dat_i = 32'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`MSPWM_ADR_GATE, 32'h0);
    bus(1'b1, `MSPWM_ADR_LEVEL, 32'h0FFF);
    rd(`MSPWM_ADR_LEVEL, 32'h0);
    bus(1'b1, `MSPWM_ADR_GATE, 32'h1);
    settle(2);
    chk(32'(pwm_oe_o), 32'h0FFF);
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, rows[i].adr, rows[i].wr);
      rd(rows[i].adr, rows[i].exp);
    end
    settle(2);
    chk(32'(pwm_o), 32'h0A5A);
    bus(1'b1, `MSPWM_ADR_PRESC, 32'h0);
    bus(1'b1, `MSPWM_ADR_CKSEL, 32'h0);
    bus(1'b1, `MSPWM_ADR_ROLE, 32'h000E);
    bus(1'b1, `MSPWM_ADR_POL, 32'h0008);
    bus(1'b1, `MSPWM_ADR_LEVEL, 32'h0);
    bus(1'b1, `MSPWM_ADR_DRIVE, 32'h000E);
    bus(1'b1, `MSPWM_ADR_RELOAD, 32'h7);
    bus(1'b1, 8'h44, 32'h3);
    bus(1'b1, 8'h48, 32'h14);
    bus(1'b1, 8'h4C, 32'h3);
    bus(1'b1, `MSPWM_ADR_GO, 32'h000F);
    rd(`MSPWM_ADR_RUN, 32'h000F);
    settle(40);
    clr <= 1'b0;
    settle(64);
    chk(32'(high_cnt[1]), 32'd24);
    chk(32'(high_cnt[2]), 32'd64);
    chk(32'(high_cnt[3]), 32'd40);
    bus(1'b0, `MSPWM_ADR_COUNT, 32'h0);
    chk(32'(q <= 32'h7), 32'h1);
    bus(1'b1, `MSPWM_ADR_HALT, 32'h000F);
    rd(`MSPWM_ADR_RUN, 32'h0);
    settle(2);
    held = pwm_o;
    bus(1'b0, `MSPWM_ADR_COUNT, 32'h0);
    cnt0 = q;
    settle(20);
    chk(32'(pwm_o), 32'(held));
    rd(`MSPWM_ADR_COUNT, cnt0);
    bus(1'b1, `MSPWM_ADR_GATE, 32'h0);
    settle(3);
    chk(32'({pwm_o, pwm_oe_o}), 32'h0);
    rd(`MSPWM_ADR_LEVEL, 32'h0);
    results();
  end
endmodule
bind mspwm_top mspwm_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_o(pwm_o),
  .pwm_oe_o(pwm_oe_o));
`default_nettype wire
